// File: hw/hsc_pkg.sv
// Shared types and constants of the halt standby controller
package hsc_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSC_ACTIVE  = 3'h0,
    HSC_ENTER   = 3'h1,
    HSC_RUNHALT = 3'h2,
    HSC_IDLE    = 3'h3,
    HSC_STOP    = 3'h4,
    HSC_WARM    = 3'h5
  } hsc_state_t;

  // ----------------------------------------------------------------
  // Halt mode encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] HSC_MODE_RUN      = 2'h0;
  localparam logic [1:0] HSC_MODE_STOP     = 2'h1;
  localparam logic [1:0] HSC_MODE_IDLE     = 2'h2;
  localparam logic [1:0] HSC_RST_HALT_MODE = 2'h0;
  localparam logic       HSC_RST_DRIVE_EN  = 1'b0;
  localparam logic       HSC_RST_WARM_LONG = 1'b0;
  localparam logic [2:0] HSC_NMI_LEVEL     = 3'h7;

  // ----------------------------------------------------------------
  // Timing: oscillator periods converted to clk_i cycles
  // ----------------------------------------------------------------
  localparam int HSC_CLK_PERIOD_NS   = 10;
  localparam int HSC_OSC_PERIOD_NS   = 10;
  localparam int HSC_ENTRY_OSC       = 3;
  localparam int HSC_WARM_SHORT_OSC  = 2 ** 14;
  localparam int HSC_WARM_LONG_OSC   = 2 ** 16;
  localparam int HSC_ENTRY_CYC       =
    (HSC_ENTRY_OSC * HSC_OSC_PERIOD_NS + HSC_CLK_PERIOD_NS - 1)
    / HSC_CLK_PERIOD_NS;
  localparam int HSC_WARM_SHORT_CYC  =
    (HSC_WARM_SHORT_OSC * HSC_OSC_PERIOD_NS + HSC_CLK_PERIOD_NS - 1)
    / HSC_CLK_PERIOD_NS;
  localparam int HSC_WARM_LONG_CYC   =
    (HSC_WARM_LONG_OSC * HSC_OSC_PERIOD_NS + HSC_CLK_PERIOD_NS - 1)
    / HSC_CLK_PERIOD_NS;
  localparam int HSC_SYNC_STAGES     = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] halt_mode;
    logic       drive_en;
    logic       warm_long;
  } hsc_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic [2:0] level;
  } hsc_irq_t;

  typedef struct packed {
    logic bus_oe_n;
    logic bus_hold;
    logic strobe_oe_n;
    logic strobe_high;
    logic clk_pin_oe_n;
    logic clk_pin_high;
    logic osc_out_high;
    logic osc_in_ignore;
    logic input_gate_off;
  } hsc_pins_t;

endpackage

// File: hw/hsc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module hsc_sync #(
  parameter int       WIDTH = 1,
  parameter bit [0:0] RST_VAL = 1'b0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) $error("hsc_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------------------------------
  // Per-bit chain; output moves only when stages two and three agree
  // ----------------------------------------------------------------
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        s1_q[b]   <= RST_VAL[0];
        s2_q[b]   <= RST_VAL[0];
        s3_q[b]   <= RST_VAL[0];
        sync_o[b] <= RST_VAL[0];
      end else begin
        s1_q[b] <= async_i[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          sync_o[b] <= s3_q[b];
        end
      end
    end
  end
endmodule

// File: hw/hsc_warmup.sv
// Oscillator warm-up counter with selectable terminal count
`timescale 1ns/10ps
module hsc_warmup #(
  parameter int SHORT_CYC = hsc_pkg::HSC_WARM_SHORT_CYC,
  parameter int LONG_CYC  = hsc_pkg::HSC_WARM_LONG_CYC
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic clear_i,
  input  wire logic run_i,
  input  wire logic long_i,
  output logic      done_o
);
  localparam int CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] SHORT_END = CW'(SHORT_CYC - 1);
  localparam logic [CW-1:0] LONG_END  = CW'(LONG_CYC - 1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] end_val;

  initial begin
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
      $error("hsc_warmup: need 1 <= SHORT_CYC <= LONG_CYC");
  end

  assign end_val = long_i ? LONG_END : SHORT_END;

  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      count_q <= '0;
      done_o  <= 1'b0;
    end else if (run_i && !done_o) begin
      if (count_q >= end_val) begin
        done_o <= 1'b1;
      end else begin
        count_q <= count_q + CW'(1);
      end
    end
  end
endmodule

// File: hw/hsc_ctrl.sv
// Halt standby controller: low-power state machine and wake logic
`timescale 1ns/10ps
module hsc_ctrl #(
  parameter int WARM_SHORT_CYC = hsc_pkg::HSC_WARM_SHORT_CYC,
  parameter int WARM_LONG_CYC  = hsc_pkg::HSC_WARM_LONG_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              cfg_we_i,
  input  wire hsc_pkg::hsc_cfg_t cfg_i,
  input  wire logic              halt_insn_i,
  input  wire logic              irq_enable_i,
  input  wire logic [2:0]        interrupt_mask_level_i,
  input  wire logic              nmi_pin_n_i,
  input  wire logic              ext_irq_zero_i,
  input  wire logic [2:0]        ext_irq_zero_level_i,
  input  wire hsc_pkg::hsc_irq_t run_irq_i,
  output hsc_pkg::hsc_cfg_t      cfg_o,
  output hsc_pkg::hsc_state_t    state_o,
  output logic                   cpu_halt_o,
  output logic                   dummy_cycle_o,
  output logic                   sys_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   osc_run_o,
  output hsc_pkg::hsc_pins_t     pins_o,
  output hsc_pkg::hsc_irq_t      svc_o,
  output logic                   resume_o,
  output hsc_pkg::hsc_irq_t      held_o
);
  localparam int EW = $clog2(hsc_pkg::HSC_ENTRY_CYC + 1);
  localparam logic [EW-1:0] ENTRY_END = EW'(hsc_pkg::HSC_ENTRY_CYC - 1);

  hsc_pkg::hsc_state_t state_q;
  hsc_pkg::hsc_state_t state_d;
  hsc_pkg::hsc_irq_t   held_q;
  hsc_pkg::hsc_irq_t   wake_q;
  hsc_pkg::hsc_irq_t   new_irq;
  hsc_pkg::hsc_irq_t   first_irq;
  hsc_pkg::hsc_irq_t   second_irq;
  logic [1:0]          target_q;
  logic [EW-1:0]       entry_q;
  logic                nmi_n_s;
  logic                ext0_s;
  logic                nmi_n_prev_q;
  logic                ext0_prev_q;
  logic                nmi_evt;
  logic                ext0_evt;
  logic                wake_now;
  logic                release_now;
  logic                warm_done;
  logic                stop_pins;
  hsc_pkg::hsc_irq_t   cur_irq;

  // ----------------------------------------------------------------
  // Pin inputs: synchronised, then edge-detected
  // ----------------------------------------------------------------
  hsc_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_nmi_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (nmi_pin_n_i),
    .sync_o  (nmi_n_s)
  );

  hsc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ext0_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (ext_irq_zero_i),
    .sync_o  (ext0_s)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      nmi_n_prev_q <= 1'b1;
      ext0_prev_q  <= 1'b0;
    end else begin
      nmi_n_prev_q <= nmi_n_s;
      ext0_prev_q  <= ext0_s;
    end
  end

  assign nmi_evt  = nmi_n_prev_q && !nmi_n_s;
  assign ext0_evt = ext0_s && !ext0_prev_q;

  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  // reset values
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_o.halt_mode <= hsc_pkg::HSC_RST_HALT_MODE;
      cfg_o.drive_en  <= hsc_pkg::HSC_RST_DRIVE_EN;
      cfg_o.warm_long <= hsc_pkg::HSC_RST_WARM_LONG;
    end else if (cfg_we_i) begin
      cfg_o <= cfg_i;
    end
  end

  // ----------------------------------------------------------------
  // Wake source selection and priority
  // ----------------------------------------------------------------
  always_comb begin
    new_irq = '0;
    if (nmi_evt) begin
      new_irq = '{valid: 1'b1, nmi: 1'b1, level: hsc_pkg::HSC_NMI_LEVEL};
    end else if (ext0_evt) begin
      new_irq = '{valid: 1'b1, nmi: 1'b0, level: ext_irq_zero_level_i};
    end else if (state_q == hsc_pkg::HSC_RUNHALT) begin
      new_irq = run_irq_i;
    end
  end

  assign wake_now = new_irq.valid &&
                    (state_q == hsc_pkg::HSC_RUNHALT ||
                     state_q == hsc_pkg::HSC_IDLE ||
                     state_q == hsc_pkg::HSC_STOP);

  // higher of new and held goes first
  // Run-halt and idle release on the wake itself, before wake_q loads
  assign cur_irq = (state_q == hsc_pkg::HSC_WARM) ? wake_q : new_irq;
  always_comb begin
    first_irq  = cur_irq;
    second_irq = held_q;
    if (held_q.valid && held_q.level > cur_irq.level) begin
      first_irq  = held_q;
      second_irq = cur_irq;
    end
  end

  assign release_now = (state_q == hsc_pkg::HSC_WARM) ? warm_done :
                       (wake_now && state_q != hsc_pkg::HSC_STOP);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      hsc_pkg::HSC_ACTIVE: begin
        if (halt_insn_i) begin
          if (cfg_o.halt_mode == hsc_pkg::HSC_MODE_IDLE ||
              cfg_o.halt_mode == hsc_pkg::HSC_MODE_STOP) begin
            state_d = hsc_pkg::HSC_ENTER;
          end else begin
            state_d = hsc_pkg::HSC_RUNHALT;
          end
        end
      end
      hsc_pkg::HSC_ENTER: begin
        if (entry_q == ENTRY_END) begin
          state_d = (target_q == hsc_pkg::HSC_MODE_STOP) ?
                    hsc_pkg::HSC_STOP : hsc_pkg::HSC_IDLE;
        end
      end
      hsc_pkg::HSC_RUNHALT,
      hsc_pkg::HSC_IDLE: begin
        if (wake_now) state_d = hsc_pkg::HSC_ACTIVE;
      end
      hsc_pkg::HSC_STOP: begin
        if (wake_now) state_d = hsc_pkg::HSC_WARM;
      end
      hsc_pkg::HSC_WARM: begin
        if (warm_done) state_d = hsc_pkg::HSC_ACTIVE;
      end
      default: state_d = hsc_pkg::HSC_ACTIVE;
    endcase
  end

  // reset leaves any state at once, no warm-up
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= hsc_pkg::HSC_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      entry_q  <= '0;
      target_q <= hsc_pkg::HSC_RST_HALT_MODE;
    end else if (state_q == hsc_pkg::HSC_ACTIVE) begin
      entry_q  <= '0;
      target_q <= cfg_o.halt_mode;
    end else if (state_q == hsc_pkg::HSC_ENTER) begin
      entry_q <= entry_q + EW'(1);
    end
  end

  // Latched wake request, consumed on release
  always_ff @(posedge clk_i) begin
    if (reset_i || release_now) begin
      wake_q <= '0;
    end else if (wake_now) begin
      wake_q <= new_irq;
    end
  end

  // ----------------------------------------------------------------
  // Held request from the entry window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      held_q <= '0;
    end else if (state_q == hsc_pkg::HSC_ENTER &&
                 (nmi_evt || ext0_evt)) begin
      // hold, set wins over any clear
      held_q <= new_irq;
    end else if (release_now) begin
      // loser of the comparison stays pending
      held_q <= second_irq;
    end else if (state_q == hsc_pkg::HSC_ACTIVE && !svc_o.valid) begin
      held_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Service or resume decision
  // ----------------------------------------------------------------
  function automatic logic takes(input hsc_pkg::hsc_irq_t r,
                                 input logic en,
                                 input logic [2:0] mask);
    takes = r.valid && (r.nmi || (en && r.level > mask));
  endfunction

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      svc_o    <= '0;
      resume_o <= 1'b0;
    end else if (release_now) begin
      if (takes(first_irq, irq_enable_i, interrupt_mask_level_i)) begin
        svc_o    <= first_irq;
        resume_o <= 1'b0;
      end else begin
        svc_o    <= '0;
        resume_o <= 1'b1;
      end
    end else if (state_q == hsc_pkg::HSC_ACTIVE && !svc_o.valid &&
                 takes(held_q, irq_enable_i, interrupt_mask_level_i)) begin
      svc_o    <= held_q;
      resume_o <= 1'b0;
    end else begin
      svc_o    <= '0;
      resume_o <= 1'b0;
    end
  end

  assign held_o = held_q;

  // ----------------------------------------------------------------
  // Warm-up counter
  // ----------------------------------------------------------------
  // counting starts with the oscillator restart
  hsc_warmup #(
    .SHORT_CYC (WARM_SHORT_CYC),
    .LONG_CYC  (WARM_LONG_CYC)
  ) u_warm (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .clear_i (state_q == hsc_pkg::HSC_ENTER),
    .run_i   (state_q == hsc_pkg::HSC_WARM),
    .long_i  (cfg_o.warm_long),
    .done_o  (warm_done)
  );

  // ----------------------------------------------------------------
  // Clock gates and pin control, registered from the next state
  // ----------------------------------------------------------------
  assign stop_pins = state_d == hsc_pkg::HSC_STOP ||
                     state_d == hsc_pkg::HSC_WARM;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_o         <= hsc_pkg::HSC_ACTIVE;
      cpu_halt_o      <= 1'b0;
      dummy_cycle_o   <= 1'b0;
      sys_clk_en_o    <= 1'b1;
      periph_clk_en_o <= 1'b1;
      osc_run_o       <= 1'b1;
    end else begin
      state_o         <= state_d;
      // CPU halted in every low-power state
      cpu_halt_o      <= state_d != hsc_pkg::HSC_ACTIVE;
      dummy_cycle_o   <= state_d == hsc_pkg::HSC_RUNHALT;
      // system clock off in idle, stop, warm-up
      sys_clk_en_o    <= !(state_d == hsc_pkg::HSC_IDLE || stop_pins);
      // peripherals stop in idle, stop, warm-up
      periph_clk_en_o <= !(state_d == hsc_pkg::HSC_IDLE || stop_pins);
      // oscillator restarts on the wake itself
      osc_run_o       <= state_d != hsc_pkg::HSC_STOP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pins_o <= '0;
    end else begin
      pins_o.bus_oe_n       <= stop_pins && !cfg_o.drive_en;
      pins_o.bus_hold       <= stop_pins && cfg_o.drive_en;
      pins_o.strobe_oe_n    <= stop_pins && !cfg_o.drive_en;
      pins_o.strobe_high    <= stop_pins && cfg_o.drive_en;
      pins_o.clk_pin_oe_n   <= stop_pins && !cfg_o.drive_en;
      pins_o.clk_pin_high   <= (stop_pins && cfg_o.drive_en) ||
                               state_d == hsc_pkg::HSC_IDLE;
      pins_o.osc_out_high   <= stop_pins;
      pins_o.osc_in_ignore  <= stop_pins;
      pins_o.input_gate_off <= stop_pins;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_stop_halt;
    state_q == hsc_pkg::HSC_ACTIVE && halt_insn_i &&
    cfg_o.halt_mode == hsc_pkg::HSC_MODE_STOP;
  endsequence
  sequence s_enter_window;
    (state_q == hsc_pkg::HSC_ENTER) [*3];
  endsequence

  AST_STOP_ENTRY: assert property (
    s_stop_halt |=> s_enter_window ##1 state_q == hsc_pkg::HSC_STOP)
    else $error("stop mode not reached after entry window");
  AST_WARM_CLK_OFF: assert property (
    state_q == hsc_pkg::HSC_WARM |-> !sys_clk_en_o && osc_run_o)
    else $error("system clock running during warm-up");
  AST_RESET_BYPASS: assert property (disable iff (1'b0)
    reset_i |=> state_q == hsc_pkg::HSC_ACTIVE && sys_clk_en_o)
    else $error("reset did not bypass warm-up");
  AST_STOP_WAKE: assert property (
    state_q == hsc_pkg::HSC_STOP && wake_now
    |=> state_q == hsc_pkg::HSC_WARM ##0 osc_run_o)
    else $error("stop wake did not start warm-up");
  AST_IDLE_IGNORE: assert property (
    state_q == hsc_pkg::HSC_IDLE && !nmi_evt && !ext0_evt
    |=> state_q == hsc_pkg::HSC_IDLE)
    else $error("idle left without qualifying source");
  AST_PERIPH: assert property (
    state_q == hsc_pkg::HSC_IDLE |-> !periph_clk_en_o && pins_o.clk_pin_high)
    else $error("peripheral clock on in idle");
  AST_FLOAT: assert property (
    state_q == hsc_pkg::HSC_STOP && !cfg_o.drive_en
    |-> pins_o.bus_oe_n && pins_o.strobe_oe_n && !pins_o.bus_hold)
    else $error("bus pins driven in stop with drive off");
  AST_HELD: assert property (
    state_q == hsc_pkg::HSC_ENTER && (nmi_evt || ext0_evt)
    |=> held_q.valid && held_q.nmi == $past(nmi_evt))
    else $error("entry-window request not held");
  AST_MASKED: assert property (
    release_now && first_irq.valid && !first_irq.nmi && !irq_enable_i
    |=> resume_o && !svc_o.valid)
    else $error("disabled wake did not resume");
  AST_RUN_WAKE: assert property (
    state_q == hsc_pkg::HSC_RUNHALT && run_irq_i.valid && !nmi_evt &&
    !ext0_evt && irq_enable_i && !held_q.valid &&
    run_irq_i.level > interrupt_mask_level_i
    |=> svc_o.valid && state_q == hsc_pkg::HSC_ACTIVE)
    else $error("unmasked run-halt wake not serviced");
endmodule

// File: test/hsc_irq_model.sv
// Model of the pin interrupt sources facing the controller
`timescale 1ns/10ps
module hsc_irq_model (
  input  wire logic clk_i,
  input  wire logic nmi_fire_i,
  input  wire logic ext0_fire_i,
  output logic      nmi_pin_n_o,
  output logic      ext_irq_zero_o
);
  // ----------------------------------------------------------------
  // Pulse stretchers
  // ----------------------------------------------------------------
  logic [2:0] nmi_q = 3'h0;
  logic [2:0] ext0_q = 3'h0;

  // pins rest at fixed level
  // Pulses outlast the three-stage agreement filter
  always_ff @(posedge clk_i) begin
    nmi_q  <= nmi_fire_i ? 3'h6 : ((nmi_q != 3'h0) ? nmi_q - 3'h1 : 3'h0);
    ext0_q <= ext0_fire_i ? 3'h6 : ((ext0_q != 3'h0) ? ext0_q - 3'h1 : 3'h0);
  end

  assign nmi_pin_n_o    = (nmi_q == 3'h0);
  assign ext_irq_zero_o = (ext0_q != 3'h0);
endmodule

// File: test/testbench.sv
// Self-checking bench of the halt standby controller
`timescale 1ns/10ps
module testbench;
  logic                clk_i = 1'b0;
  logic                reset_i = 1'b1;
  logic                cfg_we_i = 1'b0;
  hsc_pkg::hsc_cfg_t   cfg_i = '0;
  logic                halt_insn_i = 1'b0;
  logic                irq_en = 1'b1;
  logic                nmi_fire = 1'b0;
  logic                ext0_fire = 1'b0;
  logic                nmi_pin_n;
  logic                ext0_pin;
  hsc_pkg::hsc_irq_t   run_irq_i = '0;
  hsc_pkg::hsc_cfg_t   cfg_o;
  hsc_pkg::hsc_state_t state_o;
  logic                cpu_halt_o;
  logic                dummy_o;
  logic                sys_en;
  logic                per_en;
  logic                osc_run_o;
  logic                resume_o;
  hsc_pkg::hsc_pins_t  pins_o;
  hsc_pkg::hsc_irq_t   svc_o;
  hsc_pkg::hsc_irq_t   held_o;
  int                  err_total = 0;
  int                  checks_done = 0;
  int                  n;

  // Short warm-up counts keep the run brief
  hsc_ctrl #(.WARM_SHORT_CYC(8), .WARM_LONG_CYC(16)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_we_i(cfg_we_i), .cfg_i(cfg_i),
    .halt_insn_i(halt_insn_i), .irq_enable_i(irq_en),
    .interrupt_mask_level_i(3'h2), .nmi_pin_n_i(nmi_pin_n),
    .ext_irq_zero_i(ext0_pin), .ext_irq_zero_level_i(3'h4),
    .run_irq_i(run_irq_i), .cfg_o(cfg_o), .state_o(state_o),
    .cpu_halt_o(cpu_halt_o), .dummy_cycle_o(dummy_o), .sys_clk_en_o(sys_en),
    .periph_clk_en_o(per_en), .osc_run_o(osc_run_o), .pins_o(pins_o),
    .svc_o(svc_o), .resume_o(resume_o), .held_o(held_o));

  hsc_irq_model src (
    .clk_i(clk_i), .nmi_fire_i(nmi_fire), .ext0_fire_i(ext0_fire),
    .nmi_pin_n_o(nmi_pin_n), .ext_irq_zero_o(ext0_pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  // no port access right before the halt
  task automatic halt_in(input logic [1:0] m, input logic d, input logic l,
                         input logic w);
    cfg_we_i = 1'b1;
    cfg_i = '{m, d, l};
    ext0_fire = w;
    cyc(1);
    cfg_we_i = 1'b0;
    ext0_fire = 1'b0;
    // Pin latency lands the early edge mid entry window
    cyc(2);
    halt_insn_i = 1'b1;
    cyc(1);
    halt_insn_i = 1'b0;
    cyc(4);
  endtask

  task automatic wait_out(input int lim);
    n = 0;
    while (svc_o.valid !== 1'b1 && resume_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_run(input logic en, input logic [2:0] lv, input logic s);
    irq_en = en;
    halt_in(hsc_pkg::HSC_MODE_RUN, 1'b0, 1'b0, 1'b0);
    chk(state_o, hsc_pkg::HSC_RUNHALT);
    chk({cpu_halt_o, dummy_o, per_en, sys_en}, 8'h0F);
    run_irq_i = '{1'b1, 1'b0, lv};
    wait_out(10);
    run_irq_i = '0;
    chk({svc_o.valid, resume_o, svc_o.level}, {s, ~s, s ? lv : 3'h0});
    cyc(1);
    chk(state_o, hsc_pkg::HSC_ACTIVE);
    irq_en = 1'b1;
    cyc(2);
  endtask

  task automatic t_idle();
    halt_in(hsc_pkg::HSC_MODE_IDLE, 1'b0, 1'b0, 1'b0);
    chk(state_o, hsc_pkg::HSC_IDLE);
    chk({per_en, sys_en, pins_o.clk_pin_high}, 8'h01);
    run_irq_i = '{1'b1, 1'b0, 3'h7};
    cyc(6);
    chk(state_o, hsc_pkg::HSC_IDLE);
    run_irq_i = '0;
    ext0_fire = 1'b1;
    cyc(1);
    ext0_fire = 1'b0;
    wait_out(12);
    chk({svc_o.valid, svc_o.level}, {5'h1, 3'h4});
    cyc(3);
  endtask

  task automatic t_stop(input logic d, input logic l, input int lim);
    halt_in(hsc_pkg::HSC_MODE_STOP, d, l, 1'b0);
    chk(state_o, hsc_pkg::HSC_STOP);
    chk({sys_en, per_en, osc_run_o}, 8'h00);
    chk({pins_o.bus_oe_n, pins_o.strobe_oe_n, pins_o.clk_pin_oe_n},
        {5'h0, {3{~d}}});
    chk({pins_o.bus_hold, pins_o.strobe_high, pins_o.clk_pin_high},
        {5'h0, {3{d}}});
    chk({pins_o.osc_out_high, pins_o.osc_in_ignore, pins_o.input_gate_off},
        8'h07);
    nmi_fire = 1'b1;
    cyc(1);
    nmi_fire = 1'b0;
    n = 0;
    while (state_o !== hsc_pkg::HSC_WARM && n < 12) begin
      cyc(1);
      n++;
    end
    chk({osc_run_o, sys_en}, 8'h02);
    wait_out(40);
    chk(n >= lim && n <= lim + 2, 8'h01);
    chk({svc_o.valid, svc_o.nmi}, 8'h03);
    cyc(3);
  endtask

  task automatic t_window();
    halt_in(hsc_pkg::HSC_MODE_STOP, 1'b0, 1'b0, 1'b1);
    chk({state_o, held_o.valid}, {hsc_pkg::HSC_STOP, 1'b1});
    nmi_fire = 1'b1;
    cyc(1);
    nmi_fire = 1'b0;
    wait_out(40);
    chk({svc_o.valid, svc_o.level}, {5'h1, hsc_pkg::HSC_NMI_LEVEL});
    cyc(1);
    wait_out(10);
    chk({svc_o.valid, svc_o.level}, {5'h1, 3'h4});
    cyc(3);
  endtask

  task automatic t_reset_stop();
    halt_in(hsc_pkg::HSC_MODE_STOP, 1'b1, 1'b1, 1'b0);
    reset_i = 1'b1;
    cyc(1);
    chk({state_o, sys_en, osc_run_o, cfg_o}, 8'h30);
    cyc(3);
    reset_i = 1'b0;
    cyc(2);
  endtask

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #50000;
    err_total++;
    end_of_test();
  end

  initial begin
    cyc(3);
    reset_i = 1'b0;
    cyc(1);
    chk({cfg_o, sys_en, per_en}, 8'h03);
    t_run(1'b1, 3'h5, 1'b1);
    t_run(1'b1, 3'h1, 1'b0);
    t_run(1'b0, 3'h6, 1'b0);
    t_idle();
    t_stop(1'b0, 1'b0, 8);
    t_stop(1'b1, 1'b1, 16);
    t_window();
    t_reset_stop();
    end_of_test();
  end
endmodule
